/* File: pwm_pkg.sv */
// Package: register map, fields, reset values and types of the PWM channel
// Overview of operation
// [RULE_01] Timer clears on the increment after it equals the period limit.
// [RULE_02] Output rises at each period start unless duty is zero.
// [RULE_03] Period end copies the written duty into the latch.
// [RULE_04] Period is (limit+1)*4*prescale clocks.
// [RULE_05] Postscaler never changes the period.
// [RULE_06] Duty is ten bits: duty register high, control bits 5:4 low.
// [RULE_07] Duty may be written any time without disturbing the period.
// [RULE_08] In PWM mode the latched duty is read-only.
// [RULE_09] Low duty bits sit in a hidden two-bit latch.
// [RULE_10] Time base is count plus two sub-count or prescaler bits.
// [RULE_11] Output falls when the time base equals the latched duty.
// [RULE_12] Duty beyond the period never matches; output keeps its level.
// [RULE_13] Resolution is log2(4*(limit+1)); ten bits at limit 255.
// [RULE_14] A two-bit select field picks one of three timers.
// [RULE_15] Each period-end match sets the selected timer's match flag.
// [RULE_16] Sleep freezes timer and state; counting resumes from the held value.
// [RULE_17] Reset restores all registers and releases the pin to input.
// [RULE_18] Software disables driver, programs, starts timer, waits for flag, enables driver.
// [RULE_19] Writing zero to control releases the pin.
package pwm_pkg;

    // ******
    // Register byte offsets
    // ******
    localparam logic [7:0] CTRL_OFS     = 8'h00;
    localparam logic [7:0] DUTY_HI_OFS  = 8'h04;
    localparam logic [7:0] DUTY_LAT_OFS = 8'h08;
    localparam logic [7:0] TSEL_OFS     = 8'h0C;
    localparam logic [7:0] DIR_OFS      = 8'h10;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h14;
    localparam logic [7:0] IRQ_EN_OFS   = 8'h18;
    localparam logic [7:0] IRQ_CLR_OFS  = 8'h1C;
    // Per-timer block: limit, control, count at base + 0x10 * index
    localparam logic [7:0] TMR_BASE_OFS = 8'h20;
    localparam logic [7:0] TMR_STRIDE   = 8'h10;
    localparam logic [7:0] LIMIT_SUB    = 8'h00;
    localparam logic [7:0] TCTRL_SUB    = 8'h04;
    localparam logic [7:0] COUNT_SUB    = 8'h08;

    // ******
    // Field positions and codes
    // ******
    localparam int DUTY_LO_POS   = 4;
    localparam int RUN_BIT_POS   = 2;
    localparam int POSTS_POS     = 3;
    localparam logic [3:0] PWM_MODE_CODE = 4'hC;
    localparam int NUM_TIMERS    = 3;

    // ******
    // Reset values
    // ******
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] LIMIT_RST  = 8'hFF;
    localparam logic [7:0] TCTRL_RST  = 8'h00;
    localparam logic [7:0] TSEL_RST   = 8'h00;
    localparam logic       DIR_RST    = 1'b1;
    localparam int         CLK_PER_TICK = 4;

    // ******
    // Shared types
    // ******
    typedef struct packed {
        logic [7:0] limit;
        logic [7:0] ctrl;
    } timer_cfg_t;

    typedef struct packed {
        logic [7:0] count;
        logic [1:0] sub;
        logic       match;
    } timer_state_t;

endpackage

/* File: period_timer.sv */
// One shared 8-bit period timer with prescaler and two-bit sub-count
`timescale 1ns/1ps
module period_timer
    import pwm_pkg::*;
(
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         ce,
    input  wire timer_cfg_t   cfg,
    input  wire logic         cnt_we,
    input  wire logic [7:0]   cnt_wdata,
    output timer_state_t      st
);
    logic [5:0] pre_reg;
    logic [7:0] count_reg;
    logic       match_reg;
    logic       run;
    logic [5:0] pre_max;
    logic       tick;
    logic [1:0] sub_bits;

    // Prescale 1, 4, 16, 16 in ticks of four clocks; postscale unused [RULE_05]
    assign run = cfg.ctrl[RUN_BIT_POS];
    assign pre_max = (cfg.ctrl[1:0] == 2'b00) ? 6'd0 :
                     (cfg.ctrl[1:0] == 2'b01) ? 6'd15 : 6'd63; // [RULE_04]
    // pre_reg counts clocks within one count
    assign tick = run && (pre_reg == ((cfg.ctrl[1:0] == 2'b00) ? 6'd3 : pre_max));
    // Sub-count: clock phase at 1:1, two prescaler bits otherwise [RULE_10]
    assign sub_bits = (cfg.ctrl[1:0] == 2'b00) ? pre_reg[1:0] :
                      (cfg.ctrl[1:0] == 2'b01) ? pre_reg[3:2] : pre_reg[5:4];
    assign st = '{count: count_reg, sub: sub_bits, match: match_reg};

    // Prescaler; held when stopped or frozen [RULE_16]
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_reg <= 6'd0;
        end else if (ce && run) begin
            pre_reg <= tick ? 6'd0 : pre_reg + 6'd1;
        end
    end

    // Counter clears on the tick after matching the limit [RULE_01]
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_reg <= 8'h00;
            match_reg <= 1'b0;
        end else if (ce) begin
            match_reg <= 1'b0;
            if (cnt_we) begin
                count_reg <= cnt_wdata;
            end else if (tick) begin
                if (count_reg == cfg.limit) begin
                    count_reg <= 8'h00; // [RULE_01]
                    match_reg <= 1'b1;
                end else begin
                    count_reg <= count_reg + 8'h01;
                end
            end
        end
    end
endmodule

/* File: pwm_channel.sv */
// Standard PWM channel with three period timers and an AXI4-Lite register slave
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module standard_pwm_channel
    import pwm_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             pwm_output_pin_o,
    output logic             pwm_output_pin_oe,
    output logic             irq
);

    // ******
    // Registers
    // ******
    logic [7:0]   ctrl_reg;
    logic [7:0]   duty_hi_reg;
    logic [7:0]   duty_lat_reg;
    logic [1:0]   duty_lo_lat_reg;
    logic [7:0]   tsel_reg;
    logic         dir_reg;
    logic [2:0]   irq_stat_reg;
    logic [2:0]   irq_en_reg;
    logic         pwm_reg;
    logic         oe_reg;
    logic         irq_reg;
    timer_cfg_t   tcfg_reg [NUM_TIMERS];
    timer_state_t tst [NUM_TIMERS];
    logic [NUM_TIMERS-1:0] cnt_we;

    // ******
    // AXI4-Lite write path: address and data taken in either order
    // ******
    logic        aw_held_reg;
    logic [7:0]  aw_addr_reg;
    logic        w_held_reg;
    logic [31:0] w_data_reg;
    logic        w_lane0_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        wr_fire;
    logic [7:0]  wa;
    logic        wr_en;
    logic [7:0]  wd;

    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wa      = aw_addr_reg;
    assign wd      = w_data_reg[7:0];
    assign wr_en   = ce && wr_fire && w_lane0_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;

    // Known write targets; others answer SLVERR
    logic wa_tmr;
    logic [1:0] wa_idx;
    logic [7:0] wa_sub;
    logic wa_known;
    assign wa_tmr = (wa >= TMR_BASE_OFS) && (wa < TMR_BASE_OFS + 8'(NUM_TIMERS * 16));
    assign wa_idx = 2'((wa - TMR_BASE_OFS) >> 4);
    assign wa_sub = (wa - TMR_BASE_OFS) & 8'h0F;
    assign wa_known = (wa == CTRL_OFS) || (wa == DUTY_HI_OFS) || (wa == DUTY_LAT_OFS) ||
                      (wa == TSEL_OFS) || (wa == DIR_OFS) || (wa == IRQ_STAT_OFS) ||
                      (wa == IRQ_EN_OFS) || (wa == IRQ_CLR_OFS) ||
                      (wa_tmr && (wa_sub == LIMIT_SUB || wa_sub == TCTRL_SUB ||
                                  wa_sub == COUNT_SUB));

    // Channel capture and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_held_reg  <= 1'b0;
            w_data_reg  <= 32'h0000_0000;
            w_lane0_reg <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= 2'b00;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg  <= 1'b1;
                w_data_reg  <= s_axi_wdata;
                w_lane0_reg <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= wa_known ? 2'b00 : 2'b10;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // ******
    // AXI4-Lite read path
    // ******
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;
    logic [7:0]  ra;
    logic        ra_tmr;
    logic [1:0]  ra_idx;
    logic [7:0]  ra_sub;
    logic [7:0]  rd_byte;
    logic        rd_ok;

    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign ra     = s_axi_araddr;
    assign ra_tmr = (ra >= TMR_BASE_OFS) && (ra < TMR_BASE_OFS + 8'(NUM_TIMERS * 16));
    assign ra_idx = 2'((ra - TMR_BASE_OFS) >> 4);
    assign ra_sub = (ra - TMR_BASE_OFS) & 8'h0F;

    // Read mux; the clear register reads as zero
    always_comb begin
        rd_byte = 8'h00;
        rd_ok   = 1'b1;
        case (ra)
            CTRL_OFS:     rd_byte = ctrl_reg;
            DUTY_HI_OFS:  rd_byte = duty_hi_reg;
            DUTY_LAT_OFS: rd_byte = duty_lat_reg;
            TSEL_OFS:     rd_byte = tsel_reg;
            DIR_OFS:      rd_byte = {7'd0, dir_reg};
            IRQ_STAT_OFS: rd_byte = {5'd0, irq_stat_reg};
            IRQ_EN_OFS:   rd_byte = {5'd0, irq_en_reg};
            IRQ_CLR_OFS:  rd_byte = 8'h00;
            default: begin
                if (ra_tmr && ra_sub == LIMIT_SUB) begin
                    rd_byte = tcfg_reg[ra_idx].limit;
                end else if (ra_tmr && ra_sub == TCTRL_SUB) begin
                    rd_byte = tcfg_reg[ra_idx].ctrl;
                end else if (ra_tmr && ra_sub == COUNT_SUB) begin
                    rd_byte = tst[ra_idx].count;
                end else begin
                    rd_ok = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= 2'b00;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_reg <= 1'b1;
                rdata_reg  <= {24'h00_0000, rd_byte};
                rresp_reg  <= rd_ok ? 2'b00 : 2'b10;
            end else if (rvalid_reg && s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // ******
    // Three shared period timers
    // ******
    genvar g;
    generate
        for (g = 0; g < NUM_TIMERS; g++) begin : g_tmr
            assign cnt_we[g] = wr_en && wa_tmr && (wa_idx == 2'(g)) && (wa_sub == COUNT_SUB);
            period_timer u_tmr (
                .aclk      (aclk),
                .aresetn   (aresetn),
                .ce        (ce),
                .cfg       (tcfg_reg[g]),
                .cnt_we    (cnt_we[g]),
                .cnt_wdata (wd),
                .st        (tst[g])
            );
            // Timer limit and control registers; reset restores defaults [RULE_17]
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    tcfg_reg[g] <= '{limit: LIMIT_RST, ctrl: TCTRL_RST};
                end else if (wr_en && wa_tmr && wa_idx == 2'(g)) begin
                    if (wa_sub == LIMIT_SUB) begin
                        tcfg_reg[g].limit <= wd;
                    end else if (wa_sub == TCTRL_SUB) begin
                        tcfg_reg[g].ctrl <= {1'b0, wd[6:0]};
                    end
                end
            end
        end
    endgenerate

    // ******
    // Selected time base and compare
    // ******
    logic [1:0]  sel;
    timer_state_t cur;
    logic [9:0]  timebase;
    logic [9:0]  duty_lat10;
    logic [9:0]  duty_new10;
    logic        pwm_mode;
    logic        period_end;
    logic        duty_hit;

    // Field value 3 falls back to the first timer
    assign sel      = (tsel_reg[1:0] == 2'b11) ? 2'b00 : tsel_reg[1:0]; // [RULE_14]
    assign cur      = tst[sel];
    assign timebase = {cur.count, cur.sub}; // [RULE_10] [RULE_13]
    assign duty_lat10 = {duty_lat_reg, duty_lo_lat_reg}; // [RULE_09]
    assign duty_new10 = {duty_hi_reg, ctrl_reg[DUTY_LO_POS+1:DUTY_LO_POS]}; // [RULE_06]
    assign pwm_mode   = (ctrl_reg[3:2] == PWM_MODE_CODE[3:2]);
    assign period_end = cur.match;
    // Duty beyond the period never equals the time base [RULE_12]
    assign duty_hit   = (timebase == duty_lat10); // [RULE_11]

    // Control and duty registers; written any time, compared only via latch [RULE_07]
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg    <= CTRL_RST;
            duty_hi_reg <= 8'h00;
            tsel_reg    <= TSEL_RST;
            dir_reg     <= DIR_RST;
            irq_en_reg  <= 3'b000;
        end else if (wr_en) begin
            if (wa == CTRL_OFS) ctrl_reg <= wd;
            if (wa == DUTY_HI_OFS) duty_hi_reg <= wd;
            if (wa == TSEL_OFS) tsel_reg <= wd;
            if (wa == DIR_OFS) dir_reg <= wd[0];
            if (wa == IRQ_EN_OFS) irq_en_reg <= wd[2:0];
        end
    end

    // Double buffer loaded at period end; writable only outside PWM mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            duty_lat_reg    <= 8'h00;
            duty_lo_lat_reg <= 2'b00;
        end else if (ce) begin
            if (pwm_mode && period_end) begin
                duty_lat_reg    <= duty_hi_reg; // [RULE_03]
                duty_lo_lat_reg <= ctrl_reg[DUTY_LO_POS+1:DUTY_LO_POS]; // [RULE_09]
            end else if (wr_en && wa == DUTY_LAT_OFS && !pwm_mode) begin
                duty_lat_reg <= wd; // [RULE_08]
            end
        end
    end

    // Output level: set at period start, cleared on duty match
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm_reg <= 1'b0;
        end else if (ce) begin
            if (!pwm_mode) begin
                pwm_reg <= 1'b0;
            end else if (period_end) begin
                pwm_reg <= (duty_new10 != 10'd0); // [RULE_02]
            end else if (duty_hit) begin
                pwm_reg <= 1'b0; // [RULE_11]
            end
        end
    end

    // Pin drive: control zero or direction bit set releases the pin
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oe_reg <= 1'b0; // [RULE_17]
        end else begin
            oe_reg <= (ctrl_reg != 8'h00) && pwm_mode && !dir_reg; // [RULE_19]
        end
    end

    // ******
    // Match flags: set beats clear in the same cycle
    // ******
    logic [2:0] flag_set;
    logic [2:0] flag_clr;
    assign flag_set = ce ? {tst[2].match, tst[1].match, tst[0].match} : 3'b000; // [RULE_15]
    assign flag_clr = (wr_en && wa == IRQ_CLR_OFS) ? wd[2:0] : 3'b000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_reg <= 3'b000;
            irq_reg      <= 1'b0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~flag_clr) | flag_set; // [RULE_15]
            irq_reg      <= |(((irq_stat_reg & ~flag_clr) | flag_set) & irq_en_reg);
        end
    end

    assign pwm_output_pin_o  = pwm_reg;
    assign pwm_output_pin_oe = oe_reg;
    assign irq               = irq_reg;

endmodule

/* File: pwm_chk.sv */
// Checker: port-level assertions for the standard PWM channel
`timescale 1ns/1ps
module pwm_chk
    import pwm_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        ce,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        pwm_output_pin_o,
    input wire logic        pwm_output_pin_oe,
    input wire logic        irq
);
    // ******
    // Handshake decode
    // ******
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // A handshake only counts with ce high
    wire aw_hs    = s_axi_awvalid && s_axi_awready && ce;
    wire w_hs     = s_axi_wvalid && s_axi_wready && ce;
    wire ctrl_clr = aw_hs && w_hs && s_axi_awaddr == CTRL_OFS && s_axi_wstrb[0]
                    && s_axi_wdata[7:0] == 8'h00;

    rst_outputs_a: assert property ($rose(aresetn) |-> !pwm_output_pin_oe
        && !pwm_output_pin_o && !irq && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs not idle after reset");
    sleep_pin_a: assert property (!ce |=> $stable(pwm_output_pin_o))
        else $error("pin moved during sleep");
    // One edge of slack for an enable write just before
    sleep_irq_a: assert property (!ce [*2] |=> $stable(irq))
        else $error("irq moved during sleep");
    ctrl_release_a: assert property (ctrl_clr |-> ##[1:4] !pwm_output_pin_oe)
        else $error("pin still driven after control cleared");
    min_period_a: assert property ($rose(pwm_output_pin_o) |=>
        !$rose(pwm_output_pin_o) [*3])
        else $error("period shorter than four clocks");
    // Sticky flags: irq drops only after a write
    irq_fall_a: assert property ($fell(irq) |-> $past(s_axi_wvalid)
        || $past(s_axi_wvalid, 2) || $past(s_axi_bvalid) || s_axi_bvalid)
        else $error("irq dropped without a write");
    wr_answer_a: assert property (aw_hs && w_hs |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid)
        else $error("read response late");
endmodule

bind standard_pwm_channel pwm_chk pwm_chk_inst (.aclk, .aresetn, .ce, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .pwm_output_pin_o, .pwm_output_pin_oe, .irq);

/* File: pwm_load_model.sv */
// Load model: pulled-down load on the PWM pin with a pulse timing monitor
`timescale 1ns/1ps
module pwm_load_model (
    input  wire logic aclk,
    input  wire logic pin_o,
    input  wire logic pin_oe,
    output logic      level,
    output int        hi_len = 0,
    output int        per_len = 0,
    output int        rises = 0
);
    logic prev  = 1'b0;
    int   hi_c  = 0;
    int   per_c = 0;
    // Pull-down on the load: an undriven pin reads low, never the last value
    assign level = pin_oe ? pin_o : 1'b0;
    // Rise to rise gives the period, rise to fall the high time
    always @(posedge aclk) begin
        prev <= level;
        per_c <= per_c + 1;
        if (level) hi_c <= hi_c + 1;
        if (level && !prev) begin
            per_len <= per_c;
            rises <= rises + 1;
            per_c <= 1;
            hi_c <= 1;
        end
        if (!level && prev) hi_len <= hi_c;
    end
endmodule

/* File: test_standard_pwm_channel.sv */
// Testbench: register-driven scenarios for the standard PWM channel
`timescale 1ns/1ps
module test_standard_pwm_channel
    import pwm_pkg::*;
;
    logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'h1;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic        pwm_output_pin_o, pwm_output_pin_oe, irq, pin_level;
    int          hi_len, per_len, rises, n_fail = 0, tests_run = 0;

    standard_pwm_channel standard_pwm_channel_inst (.aclk, .aresetn, .ce, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .pwm_output_pin_o, .pwm_output_pin_oe, .irq);
    pwm_load_model pwm_load_model_inst (.aclk, .pin_o(pwm_output_pin_o),
        .pin_oe(pwm_output_pin_oe), .level(pin_level), .hi_len, .per_len, .rises);

    always #2 aclk = ~aclk;

    // ******
    // Shared tasks
    // ******
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Ready sampled mid-cycle, acted on at the next edge
    task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        logic a_ok, w_ok, ar_ok, done;
        n = 0;
        done = 1'b0;
        @(posedge aclk);
        if (wr) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
        end
        while (!done && n < 200) begin
            @(negedge aclk);
            n++;
            a_ok = s_axi_awvalid && s_axi_awready;
            w_ok = s_axi_wvalid && s_axi_wready;
            ar_ok = s_axi_arvalid && s_axi_arready;
            done = wr ? s_axi_bvalid : s_axi_rvalid;
            rsp = wr ? s_axi_bresp : s_axi_rresp;
            rd = s_axi_rdata;
            @(posedge aclk);
            if (a_ok) s_axi_awvalid <= 1'b0;
            if (w_ok) s_axi_wvalid <= 1'b0;
            if (ar_ok) s_axi_arvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        if (!done) n_fail++;
    endtask
    task automatic duty(input logic [9:0] d);
        bus(1, CTRL_OFS, {26'h000_0000, d[1:0], PWM_MODE_CODE});
        bus(1, DUTY_HI_OFS, {24'h00_0000, d[9:2]});
    endtask
    task automatic measure(input int per, input int hi);
        repeat (3 * per + 8) @(posedge aclk);
        @(negedge aclk);
        check("period", per_len, per);
        check("high time", hi_len, hi);
    endtask
    task automatic hold_check(input int span);
        int r0;
        logic lvl;
        @(negedge aclk);
        r0 = rises;
        lvl = pin_level;
        repeat (span) @(negedge aclk);
        check("held level", {31'h0, pin_level}, {31'h0, lvl});
        check("held edges", rises, r0);
    endtask
    // Driver off, program, start, wait for a full period, driver on
    task automatic setup(input int t, input logic [7:0] lim, input logic [1:0] ps);
        logic [7:0] base;
        int n;
        base = TMR_BASE_OFS + TMR_STRIDE * 8'(t);
        bus(1, DIR_OFS, 32'h0000_0001);
        bus(1, base + LIMIT_SUB, {24'h00_0000, lim});
        duty(10'd6);
        bus(1, TSEL_OFS, {30'h0, 2'(t)});
        bus(1, IRQ_CLR_OFS, 32'h0000_0007);
        // Postscale all ones must not alter the period
        bus(1, base + TCTRL_SUB, {24'h00_0000, 1'b0, 4'hF, 1'b1, ps});
        n = 0;
        do begin
            bus(0, IRQ_STAT_OFS, 0);
            n++;
        end while (rd[t] !== 1'b1 && n < 400);
        check("match flag", {31'h0, rd[t]}, 32'h1);
        bus(1, DIR_OFS, 32'h0000_0000);
    endtask

    // ******
    // Scenarios
    // ******
    task automatic t_reset();
        bus(0, CTRL_OFS, 0);
        check("control reset", rd, 32'h0000_0000);
        bus(0, DIR_OFS, 0);
        check("direction reset", rd, {31'h0, DIR_RST});
        bus(0, TMR_BASE_OFS + LIMIT_SUB, 0);
        check("limit reset", rd, {24'h00_0000, LIMIT_RST});
        check("drive reset", {31'h0, pwm_output_pin_oe}, 32'h0);
        bus(0, 8'hFC, 0);
        check("unmapped resp", {30'h0, rsp}, 32'h0000_0002);
    endtask
    task automatic t_basic();
        setup(0, 8'h03, 2'b00);
        measure(16, 6);
        check("drive on", {31'h0, pwm_output_pin_oe}, 32'h1);
        bus(0, DUTY_LAT_OFS, 0);
        check("latched duty", rd, 32'h0000_0001);
        bus(1, DUTY_LAT_OFS, 32'h0000_00AA);
        check("write resp", {30'h0, rsp}, 32'h0);
        bus(0, DUTY_LAT_OFS, 0);
        check("latched duty ro", rd, 32'h0000_0001);
    endtask
    task automatic t_duty();
        duty(10'd11);
        measure(16, 11);
        duty(10'h040);
        repeat (40) @(posedge aclk);
        hold_check(40);
        check("over level", {31'h0, pin_level}, 32'h1);
        duty(10'h000);
        repeat (40) @(posedge aclk);
        hold_check(40);
        check("zero level", {31'h0, pin_level}, 32'h0);
        duty(10'd6);
    endtask
    task automatic t_prescale();
        int f;
        // Codes 10 and 11 both divide by sixteen
        for (int i = 0; i < 4; i++) begin
            f = (i == 3) ? 16 : (1 << (2 * i));
            bus(1, TMR_BASE_OFS + TCTRL_SUB, {24'h00_0000, 1'b0, 4'hF, 1'b1, 2'(i)});
            measure(16 * f, 6 * f);
        end
    endtask
    task automatic t_select();
        setup(1, 8'h07, 2'b00);
        measure(32, 6);
        bus(1, TSEL_OFS, 32'h0000_0003);
        measure(256, 96);
    endtask
    task automatic t_sleep();
        @(posedge aclk);
        ce <= 1'b0;
        hold_check(300);
        @(posedge aclk);
        ce <= 1'b1;
        measure(256, 96);
    endtask
    task automatic t_irq();
        bus(1, IRQ_EN_OFS, 32'h0000_0001);
        repeat (3) @(negedge aclk);
        check("irq raised", {31'h0, irq}, 32'h1);
        bus(1, IRQ_EN_OFS, 32'h0000_0000);
        repeat (3) @(negedge aclk);
        check("irq masked", {31'h0, irq}, 32'h0);
        bus(1, TMR_BASE_OFS + TCTRL_SUB, 32'h0000_0000);
        bus(1, IRQ_CLR_OFS, 32'h0000_0001);
        bus(1, IRQ_EN_OFS, 32'h0000_0001);
        bus(0, IRQ_STAT_OFS, 0);
        check("flag cleared", {31'h0, rd[0]}, 32'h0);
        check("irq cleared", {31'h0, irq}, 32'h0);
    endtask
    task automatic t_release();
        bus(1, CTRL_OFS, 32'h0000_0000);
        repeat (3) @(negedge aclk);
        check("drive released", {31'h0, pwm_output_pin_oe}, 32'h0);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        bus(0, TMR_BASE_OFS + TMR_STRIDE + LIMIT_SUB, 0);
        check("limit after reset", rd, {24'h00_0000, LIMIT_RST});
    endtask

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_basic();
        t_duty();
        t_prescale();
        t_select();
        t_sleep();
        t_irq();
        t_release();
        tally_and_finish();
    end
    // Watchdog
    initial begin
        #200_000;
        n_fail++;
        tally_and_finish();
    end
endmodule
